// ===== src/port_rate_pkg.sv
// Purpose: Constants and carriers for the port rate limit and cable diagnostic bank
// Assumes: Classic Wishbone with 32-bit data, one register per aligned word
// Notes: Printed offsets are register indices; byte address is index times four
package port_rate_pkg;

	// Register indices
	localparam logic [7:0] idx_ingress_rate_prio1_prio0 = 8'h8c;
	localparam logic [7:0] idx_ingress_rate_prio3_prio2 = 8'h8e;
	localparam logic [7:0] idx_egress_rate_prio1_prio0 = 8'h90;
	localparam logic [7:0] idx_egress_rate_prio3_prio2 = 8'h92;
	localparam logic [7:0] idx_phy_cable_diag_ctrl_status = 8'h94;
	localparam logic [7:0] idx_rate_ctrl = 8'ha0;
	localparam logic [7:0] idx_irq_status = 8'ha1;
	localparam logic [7:0] idx_irq_mask = 8'ha2;

	// Rate word field positions
	localparam int hi_code_lsb = 8;
	localparam int lo_code_lsb = 0;

	// Diagnostic word field positions
	localparam int diag_near_short_bit = 15;
	localparam int diag_result_lsb = 13;
	localparam int diag_start_bit = 12;
	localparam int diag_force_link_bit = 11;
	localparam int diag_reserved_bit = 10;
	localparam int diag_loopback_bit = 9;
	localparam int diag_count_lsb = 0;

	// Rate control word field positions
	localparam int rctl_pre_bit = 0;
	localparam int rctl_ifg_bit = 1;
	localparam int rctl_mode_lsb = 2;
	localparam int rctl_queues_lsb = 4;

	// Reset values
	localparam logic [6:0] rate_code_reset = 7'h00;
	localparam logic [1:0] queues_reset = 2'h0;
	localparam logic diag_reserved_reset = 1'b1;

	// Extra bytes added per frame
	localparam logic [3:0] ifg_bytes = 4'hc;
	localparam logic [3:0] preamble_bytes = 4'h8;

	typedef enum logic [1:0] {
		queues_one = 2'b00,
		queues_two = 2'b01,
		queues_four = 2'b10
	} queue_cfg_t;

	typedef enum logic [1:0] {
		limit_all = 2'b00,
		limit_bc_mc_flood = 2'b01,
		limit_bc_mc = 2'b10,
		limit_bc = 2'b11
	} limit_mode_t;

	typedef enum logic [1:0] {
		cdt_idle = 2'b00,
		cdt_run = 2'b01
	} cdt_state_t;

	// Four rate codes, index is priority
	typedef struct packed {
		logic [3:0][6:0] code;
	} rate_set_t;

	// Result from the PHY cable tester
	typedef struct packed {
		logic done;
		logic near_short;
		logic [1:0] result;
		logic [8:0] count;
	} cdt_result_t;

	// Wishbone slave side
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} wb_resp_t;

	// Whole block state
	typedef struct packed {
		rate_set_t ingress;
		rate_set_t egress;
		queue_cfg_t queues;
		limit_mode_t mode;
		logic count_ifg;
		logic count_pre;
		cdt_state_t cdt;
		logic start;
		logic near_short;
		logic [1:0] result;
		logic [8:0] count;
		logic force_link;
		logic reserved10;
		logic loopback;
		logic [1:0] irq_status;
		logic [1:0] irq_mask;
		wb_resp_t wb;
	} bank_state_t;

endpackage

// ===== src/port_rate_limit_cable_diag_regs.sv
// Purpose: Per-port rate limit codes and cable diagnostic control/status bank
// Assumes: Cable tester result arrives on mclk as a one-cycle done pulse
// Notes: Code-to-bandwidth translation lives outside; this bank hands codes over
//
// Summary of operation
// RULE1 - Ingress word zero bits 14:8: priority 1 code
// RULE2 - Ingress word zero bits 6:0: priority 0 code
// RULE3 - Code zero means no limit, full rate
// RULE4 - Ingress word one: priority 3 high, 2 low
// RULE5 - Egress word zero: priority 1/0; throttle only
// RULE6 - Egress word one: priority 3 high, 2 low
// RULE7 - One queue: only priority 0 egress applied
// RULE8 - Two queues: only priorities 1, 0 applied
// RULE9 - Bit 15 reads one for near short
// RULE10 - Bits 14:13 give cable test outcome
// RULE11 - Bit 12 starts test, self-clears when done
// RULE12 - Bit 11 forces link pass
// RULE13 - Bit 9 enables near-end remote loopback
// RULE14 - Bits 8:0 give fault distance count
// RULE15 - Nonzero codes go to external speed-selected table
// RULE16 - Ingress mode selects which frames are limited
// RULE17 - IFG option adds 12 bytes per frame
// RULE18 - Preamble option adds 8 bytes per frame
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module port_rate_limit_cable_diag_regs
	import port_rate_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Cable tester in the PHY
	output logic cdt_start,
	input wire cdt_result_t cdt_in,
	// PHY controls
	output logic force_link,
	output logic near_loopback,
	// Shaper hand-over
	output rate_set_t ingress_codes,
	output rate_set_t egress_codes,
	output logic [3:0] ingress_limited,
	output logic [3:0] egress_limited,
	output limit_mode_t ingress_mode,
	output logic [4:0] extra_bytes,
	// Interrupt
	output logic irq
);

	bank_state_t state;
	bank_state_t next_state;
	logic [7:0] idx;
	logic access;
	logic wr;
	logic [15:0] wdat;
	logic [15:0] rdat;
	logic [3:0] egress_enable;
	logic [1:0] events;

	assign idx = adr_i[9:2];
	assign access = cyc_i && stb_i && !state.wb.ack;
	assign wr = access && we_i;

	// Byte lanes merged onto current word for partial writes
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [3:0] sel,
		input logic [31:0] d);
		merge = old;
		if (sel[0]) begin
			merge[7:0] = d[7:0];
		end
		if (sel[1]) begin
			merge[15:8] = d[15:8];
		end
	endfunction

	// Read mux; unmapped words read zero
	always_comb begin
		rdat = 16'h0000;
		case (idx)
			idx_ingress_rate_prio1_prio0: begin
				rdat = {1'b0, state.ingress.code[1], 1'b0, state.ingress.code[0]}; // [RULE1] [RULE2]
			end
			idx_ingress_rate_prio3_prio2: begin
				rdat = {1'b0, state.ingress.code[3], 1'b0, state.ingress.code[2]}; // [RULE4]
			end
			idx_egress_rate_prio1_prio0: begin
				rdat = {1'b0, state.egress.code[1], 1'b0, state.egress.code[0]}; // [RULE5]
			end
			idx_egress_rate_prio3_prio2: begin
				rdat = {1'b0, state.egress.code[3], 1'b0, state.egress.code[2]}; // [RULE6]
			end
			idx_phy_cable_diag_ctrl_status: begin
				rdat[diag_near_short_bit] = state.near_short; // [RULE9]
				rdat[diag_result_lsb +: 2] = state.result; // [RULE10]
				rdat[diag_start_bit] = state.start; // [RULE11]
				rdat[diag_force_link_bit] = state.force_link;
				rdat[diag_reserved_bit] = state.reserved10;
				rdat[diag_loopback_bit] = state.loopback;
				rdat[diag_count_lsb +: 9] = state.count; // [RULE14]
			end
			idx_rate_ctrl: begin
				rdat[rctl_pre_bit] = state.count_pre;
				rdat[rctl_ifg_bit] = state.count_ifg;
				rdat[rctl_mode_lsb +: 2] = state.mode;
				rdat[rctl_queues_lsb +: 2] = state.queues;
			end
			idx_irq_status: begin
				rdat[1:0] = state.irq_status;
			end
			idx_irq_mask: begin
				rdat[1:0] = state.irq_mask;
			end
			default: begin
				rdat = 16'h0000;
			end
		endcase
	end

	// Events: bit 0 test done, bit 1 start accepted
	assign events = {wr && idx == idx_phy_cable_diag_ctrl_status && sel_i[1]
		&& dat_i[diag_start_bit] && state.cdt == cdt_idle,
		state.cdt == cdt_run && cdt_in.done};

	// Next-state logic for bus, registers and cable test sequence
	always_comb begin
		next_state = state;
		wdat = 16'h0000;
		next_state.wb.ack = access;
		next_state.wb.dat = access ? {16'h0000, rdat} : state.wb.dat;
		if (wr) begin
			case (idx)
				idx_ingress_rate_prio1_prio0: begin
					wdat = merge(rdat, sel_i, dat_i);
					next_state.ingress.code[1] = wdat[hi_code_lsb +: 7]; // [RULE1]
					next_state.ingress.code[0] = wdat[lo_code_lsb +: 7]; // [RULE2]
				end
				idx_ingress_rate_prio3_prio2: begin
					wdat = merge(rdat, sel_i, dat_i);
					next_state.ingress.code[3] = wdat[hi_code_lsb +: 7]; // [RULE4]
					next_state.ingress.code[2] = wdat[lo_code_lsb +: 7]; // [RULE4]
				end
				idx_egress_rate_prio1_prio0: begin
					wdat = merge(rdat, sel_i, dat_i);
					next_state.egress.code[1] = wdat[hi_code_lsb +: 7]; // [RULE5]
					next_state.egress.code[0] = wdat[lo_code_lsb +: 7]; // [RULE5]
				end
				idx_egress_rate_prio3_prio2: begin
					wdat = merge(rdat, sel_i, dat_i);
					next_state.egress.code[3] = wdat[hi_code_lsb +: 7]; // [RULE6]
					next_state.egress.code[2] = wdat[lo_code_lsb +: 7]; // [RULE6]
				end
				idx_phy_cable_diag_ctrl_status: begin
					wdat = merge(rdat, sel_i, dat_i);
					next_state.force_link = wdat[diag_force_link_bit]; // [RULE12]
					next_state.reserved10 = wdat[diag_reserved_bit];
					next_state.loopback = wdat[diag_loopback_bit]; // [RULE13]
				end
				idx_rate_ctrl: begin
					wdat = merge(rdat, sel_i, dat_i);
					next_state.count_pre = wdat[rctl_pre_bit]; // [RULE18]
					next_state.count_ifg = wdat[rctl_ifg_bit]; // [RULE17]
					next_state.mode = limit_mode_t'(wdat[rctl_mode_lsb +: 2]); // [RULE16]
					next_state.queues = queue_cfg_t'(wdat[rctl_queues_lsb +: 2]);
				end
				idx_irq_mask: begin
					wdat = merge(rdat, sel_i, dat_i);
					next_state.irq_mask = wdat[1:0];
				end
				default: begin
					wdat = 16'h0000;
				end
			endcase
		end
		// Cable test: start runs until the tester reports done
		case (state.cdt)
			cdt_idle: begin
				if (events[1]) begin
					next_state.start = 1'b1; // [RULE11]
					next_state.cdt = cdt_run;
				end
			end
			cdt_run: begin
				if (cdt_in.done) begin
					next_state.start = 1'b0; // [RULE11]
					next_state.near_short = cdt_in.near_short; // [RULE9]
					next_state.result = cdt_in.result; // [RULE10]
					next_state.count = cdt_in.count; // [RULE14]
					next_state.cdt = cdt_idle;
				end
			end
			default: begin
				next_state.cdt = cdt_idle;
				next_state.start = 1'b0;
			end
		endcase
		// Sticky status, write one clears, set wins
		if (wr && idx == idx_irq_status && sel_i[0]) begin
			next_state.irq_status = state.irq_status & ~dat_i[1:0];
		end
		next_state.irq_status = next_state.irq_status | events;
	end

	// State register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
			state.ingress.code <= {4{rate_code_reset}}; // [RULE3]
			state.egress.code <= {4{rate_code_reset}}; // [RULE3]
			state.queues <= queue_cfg_t'(queues_reset); // [RULE7]
			state.reserved10 <= diag_reserved_reset;
			state.cdt <= cdt_idle;
		end else begin
			state <= next_state;
		end
	end

	// Egress codes applied by queue count
	always_comb begin
		case (state.queues)
			queues_one: begin
				egress_enable = 4'b0001; // [RULE7]
			end
			queues_two: begin
				egress_enable = 4'b0011; // [RULE8]
			end
			default: begin
				egress_enable = 4'b1111;
			end
		endcase
	end

	// Code zero means unlimited; shaper maps the rest by speed
	genvar p;
	generate
		for (p = 0; p < 4; p++) begin : g_prio
			assign ingress_limited[p] = |state.ingress.code[p]; // [RULE3] [RULE15]
			assign egress_limited[p] = egress_enable[p] && |state.egress.code[p]; // [RULE5]
			assign ingress_codes.code[p] = state.ingress.code[p];
			assign egress_codes.code[p] = egress_enable[p] ? state.egress.code[p] : 7'h00;
		end
	endgenerate

	// Outputs
	assign extra_bytes = (state.count_ifg ? {1'b0, ifg_bytes} : 5'h00)
		+ (state.count_pre ? {1'b0, preamble_bytes} : 5'h00); // [RULE17] [RULE18]
	assign ingress_mode = state.mode; // [RULE16]
	assign cdt_start = state.start;
	assign force_link = state.force_link; // [RULE12]
	assign near_loopback = state.loopback; // [RULE13]
	assign irq = |(state.irq_status & state.irq_mask);
	assign dat_o = state.wb.dat;
	assign ack_o = state.wb.ack;

endmodule
`default_nettype wire

// ===== tb/port_rate_chk.sv
// Purpose: Port assertions for the rate limit and cable diagnostic bank
// Assumes: Registered ack one cycle after take, single clock
// Notes: Bound to every instance of the bank
`timescale 1ns/1ps
`default_nettype none
module port_rate_chk
	import port_rate_pkg::*;
(
	// Clock, reset and bus
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic ack_o,
	// Block side
	input wire logic cdt_start,
	input wire cdt_result_t cdt_in,
	input wire logic force_link,
	input wire logic near_loopback,
	input wire rate_set_t ingress_codes,
	input wire rate_set_t egress_codes,
	input wire logic [3:0] ingress_limited,
	input wire logic [3:0] egress_limited,
	input wire logic [4:0] extra_bytes
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Bus take and test start request
	sequence s_take;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_start_req;
		s_take ##0 (we_i && sel_i[1] && dat_i[12] && !cdt_start
			&& adr_i[9:2] == idx_phy_cable_diag_ctrl_status);
	endsequence
	a_ack_one: assert property (s_take |=> ack_o)
		else $error("ack missing after take");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_start_soon: assert property (s_start_req |=> cdt_start)
		else $error("test did not start");
	a_start_cause: assert property ($rose(cdt_start) |-> $past(we_i && dat_i[12]))
		else $error("test started without write");
	a_start_stands: assert property (cdt_start && !cdt_in.done |=> cdt_start)
		else $error("test bit cleared early");
	a_start_clear: assert property (cdt_start && cdt_in.done |=> !cdt_start)
		else $error("test bit not self cleared");
	a_force_hold: assert property ($changed(force_link) |-> ack_o)
		else $error("force link changed without access");
	a_loop_hold: assert property ($changed(near_loopback) |-> ack_o)
		else $error("loopback changed without access");
	a_ing_flag: assert property (ingress_limited == {|ingress_codes.code[3],
		|ingress_codes.code[2], |ingress_codes.code[1], |ingress_codes.code[0]})
		else $error("ingress limit flags wrong");
	a_egr_flag: assert property (egress_limited == {|egress_codes.code[3],
		|egress_codes.code[2], |egress_codes.code[1], |egress_codes.code[0]})
		else $error("egress limit flags wrong");
	a_extra_set: assert property (extra_bytes inside {5'h00, 5'h08, 5'h0c, 5'h14})
		else $error("extra byte count illegal");
endmodule
bind port_rate_limit_cable_diag_regs port_rate_chk port_rate_chk_i (.mclk(mclk),
	.rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .cdt_start(cdt_start), .cdt_in(cdt_in),
	.force_link(force_link), .near_loopback(near_loopback), .ingress_codes(ingress_codes),
	.egress_codes(egress_codes), .ingress_limited(ingress_limited),
	.egress_limited(egress_limited), .extra_bytes(extra_bytes));
`default_nettype wire

// ===== tb/port_rate_limit_cable_diag_regs_tb.sv
// Purpose: Self-checking bench for the rate limit and cable diagnostic bank
// Assumes: Classic Wishbone master, cable tester replaced by bench pulses
// Notes: Offsets are word indices, byte address is index times four
`timescale 1ns/1ps
`default_nettype none
module port_rate_limit_cable_diag_regs_tb;
	import port_rate_pkg::*;
	logic mclk = 0, rst_n = 0, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [9:0] adr_i = '0;
	logic [3:0] sel_i = '0;
	logic [31:0] dat_i = '0, dat_o, rd;
	logic ack_o, cdt_start, force_link, near_loopback, irq;
	cdt_result_t cdt_in = '0;
	rate_set_t ingress_codes, egress_codes;
	logic [3:0] ingress_limited, egress_limited;
	limit_mode_t ingress_mode;
	logic [4:0] extra_bytes;
	int fails = 0, comparisons = 0, cycles = 0;
	always #20 mclk = ~mclk;
	port_rate_limit_cable_diag_regs port_rate_limit_cable_diag_regs_i (.mclk(mclk),
		.rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cdt_start(cdt_start),
		.cdt_in(cdt_in), .force_link(force_link), .near_loopback(near_loopback),
		.ingress_codes(ingress_codes), .egress_codes(egress_codes),
		.ingress_limited(ingress_limited), .egress_limited(egress_limited),
		.ingress_mode(ingress_mode), .extra_bytes(extra_bytes), .irq(irq));
	// Verdict and end of run
	task automatic wrap_up;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// One classic cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [7:0] idx, input logic [15:0] d);
		@(posedge mclk);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= we;
		adr_i <= {idx, 2'b00};
		sel_i <= 4'h3;
		dat_i <= {16'h0000, d};
		do @(posedge mclk); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
		we_i <= 0;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [15:0] d);
		wb(1, idx, d);
		step(1);
	endtask
	task automatic rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
		wb(0, idx, 16'h0000);
		check(what, rd, exp);
	endtask
	task automatic t_reset;
		rdchk("diag", idx_phy_cable_diag_ctrl_status, 32'h0000_0400);
		rdchk("ing0", idx_ingress_rate_prio1_prio0, 32'h0000_0000);
		rdchk("unmapped", 8'hff, 32'h0000_0000);
		check("egc", egress_codes, 32'h0000_0000);
		check("rstout", {irq, cdt_start, force_link, near_loopback}, 0);
		$display("reset test done");
	endtask
	task automatic t_rates;
		wr(idx_ingress_rate_prio1_prio0, 16'h1a2b);
		wr(idx_ingress_rate_prio3_prio2, 16'h3c4d);
		wr(idx_egress_rate_prio1_prio0, 16'h1122);
		wr(idx_egress_rate_prio3_prio2, 16'h3344);
		rdchk("ing0", idx_ingress_rate_prio1_prio0, 32'h0000_1a2b);
		check("ingc", ingress_codes, {7'h3c, 7'h4d, 7'h1a, 7'h2b});
		check("egc1", egress_codes, {21'h00_0000, 7'h22});
		check("egl1", egress_limited, 4'h1);
		wr(idx_rate_ctrl, 16'h0010);
		check("egc2", egress_codes, {14'h0000, 7'h11, 7'h22});
		wr(idx_rate_ctrl, 16'h0020);
		check("egc4", egress_codes, {7'h33, 7'h44, 7'h11, 7'h22});
		wr(idx_ingress_rate_prio1_prio0, 16'h0000);
		check("ingl", ingress_limited, 4'hc);
		$display("rate test done");
	endtask
	task automatic t_modes;
		for (int i = 0; i < 4; i++) begin
			wr(idx_rate_ctrl, 16'(i * 5));
			check("mode", ingress_mode, i);
			check("extra", extra_bytes, (i % 2) * 8 + (i / 2) * 12);
		end
		$display("mode test done");
	endtask
	task automatic t_diag;
		wr(idx_irq_mask, 16'h0003);
		wr(idx_phy_cable_diag_ctrl_status, 16'h0e00);
		check("force", force_link, 1);
		check("loop", near_loopback, 1);
		wr(idx_phy_cable_diag_ctrl_status, 16'h0400);
		check("force0", {force_link, near_loopback}, 0);
		for (int i = 0; i < 4; i++) begin
			wr(idx_irq_mask, 16'(i == 3 ? 0 : 3));
			wr(idx_phy_cable_diag_ctrl_status, 16'h1400);
			check("start", cdt_start, 1);
			check("irq", irq, i != 3);
			rdchk("run", idx_phy_cable_diag_ctrl_status, i == 0 ? 32'h0000_1400
				: ((i - 1) % 2) * 32'h8000 + (i - 1) * 32'h2000 + 32'h1500 + i - 1);
			@(posedge mclk) cdt_in <= {1'b1, i[0], i[1:0], 9'(9'h100 + i)};
			@(posedge mclk) cdt_in <= '0;
			step(1);
			check("stop", cdt_start, 0);
			rdchk("res", idx_phy_cable_diag_ctrl_status,
				(i % 2) * 32'h8000 + i * 32'h2000 + 32'h0500 + i);
			rdchk("ists", idx_irq_status, 32'h0000_0003);
			wr(idx_irq_status, 16'h0003);
			check("irq0", irq, 0);
		end
		$display("diag test done");
	endtask
	// Hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles > 5000) begin
			fails++;
			wrap_up;
		end
	end
	initial begin
		repeat (2) @(posedge mclk);
		rst_n <= 1;
		t_reset;
		t_rates;
		t_modes;
		t_diag;
		wrap_up;
	end
endmodule
`default_nettype wire
